/* File: hdl/fpcro_top.v */
// Purpose: parameter checks for flash program/erase plus ram overlay
// Assumes: inputs other than RESET_N synchronous to CORE_CLK; source memory answers one cycle
//          after a read enable
// Notes:   software keeps overlay writes to user modes and waits before
//          touching the emulated block
`include "fpcro_map.vh"
`timescale 1ns/10ps
`default_nettype none

module fpcro_top #(
    parameter [31:0] FLASH_LAST = `FPCRO_FLASH_LAST
) (
    // clock and reset
    input  wire        CORE_CLK,
    input  wire        RESET_N,
    // routine parameters from cpu general registers
    input  wire [31:0] PROG_DEST_ADDR,
    input  wire [31:0] PROG_SRC_ADDR,
    input  wire [31:0] ERASE_BLOCK_NUM,
    // routine commands
    input  wire        PROG_START,
    input  wire        ERASE_START,
    // routine status
    output wire        BUSY,
    output wire        DONE,
    output wire [7:0]  RESULT_FLAGS,
    // source data fetch
    output wire        SRC_RD_EN,
    output wire [31:0] SRC_RD_ADDR,
    input  wire [7:0]  SRC_RD_DATA,
    // flash array write and erase
    output wire        FLASH_WE,
    output wire [31:0] FLASH_WADDR,
    output wire [7:0]  FLASH_WDATA,
    output wire        FLASH_ERASE,
    output wire [3:0]  FLASH_ERASE_BLOCK,
    // overlay control register
    input  wire        OVL_CTL_WE,
    input  wire [7:0]  OVL_CTL_WDATA,
    output wire [7:0]  OVL_CTL_RDATA,
    // cpu read redirection
    input  wire [23:0] CPU_ADDR,
    output wire        OVL_HIT,
    output wire [23:0] OVL_ADDR
);

    reg  [1:0]  state_r;
    reg  [1:0]  state_nxt;
    reg  [7:0]  rd_cnt_r;
    reg  [7:0]  rd_cnt_nxt;
    reg  [6:0]  wr_cnt_r;
    reg  [31:0] dest_r;
    reg  [31:0] src_r;
    reg         rd_en_r;
    reg         rd_pend_r;
    reg         last_wr_r;
    reg         flash_we_r;
    reg  [31:0] flash_addr_r;
    reg  [7:0]  flash_data_r;
    reg         erase_r;
    reg  [3:0]  erase_blk_r;
    reg  [7:0]  result_r;
    reg  [7:0]  result_nxt;
    reg         done_r;
    reg         done_nxt;
    reg         erase_nxt;

    wire        emu_on;
    wire        wa_err;
    wire        wd_err;
    wire        eb_err;
    wire        prog_ok;
    wire        erase_ok;

    fpcro_overlay u_overlay (
        .clk       (CORE_CLK),
        .reset_n   (RESET_N),
        .ctl_we    (OVL_CTL_WE),
        .ctl_wdata (OVL_CTL_WDATA),
        .ctl_rdata (OVL_CTL_RDATA),
        .cpu_addr  (CPU_ADDR),
        .ovl_hit   (OVL_HIT),
        .ovl_addr  (OVL_ADDR),
        .emu_on    (emu_on)
    );

    // parameter checks, flash assumed to start at address zero
    assign wa_err = (PROG_DEST_ADDR[`FPCRO_ALIGN_BITS-1:0] != 7'h00) ||
                    (PROG_DEST_ADDR > FLASH_LAST);
    assign wd_err = (PROG_SRC_ADDR <= FLASH_LAST);
    assign eb_err = (ERASE_BLOCK_NUM > `FPCRO_BLOCK_LAST);

    // emulation protects every block, so no array activity may start
    assign prog_ok  = !wa_err && !wd_err && !emu_on;
    assign erase_ok = !eb_err && !emu_on;

    // command sequencer
    always @* begin
        state_nxt  = state_r;
        rd_cnt_nxt = rd_cnt_r;
        result_nxt = result_r;
        done_nxt   = 1'b0;
        erase_nxt  = 1'b0;
        case (state_r)
            `FPCRO_ST_IDLE: begin
                if (PROG_START) begin
                    result_nxt = 8'h00;
                    result_nxt[`FPCRO_WA_BIT] = wa_err;
                    result_nxt[`FPCRO_WD_BIT] = wd_err;
                    result_nxt[`FPCRO_SF_BIT] = !prog_ok;
                    rd_cnt_nxt = 8'h00;
                    if (prog_ok) begin
                        state_nxt = `FPCRO_ST_PROG;
                    end else begin
                        done_nxt = 1'b1;
                    end
                end else if (ERASE_START) begin
                    result_nxt = 8'h00;
                    result_nxt[`FPCRO_EB_BIT] = eb_err;
                    result_nxt[`FPCRO_SF_BIT] = !erase_ok;
                    erase_nxt = erase_ok;
                    done_nxt  = 1'b1;
                end
            end
            `FPCRO_ST_PROG: begin
                if (rd_cnt_r != `FPCRO_PROG_BYTES) begin
                    rd_cnt_nxt = rd_cnt_r + 8'h01;
                end
                if (last_wr_r) begin
                    state_nxt = `FPCRO_ST_DONE;
                end
            end
            `FPCRO_ST_DONE: begin
                done_nxt  = 1'b1;
                state_nxt = `FPCRO_ST_IDLE;
            end
            default: begin
                state_nxt = `FPCRO_ST_IDLE;
            end
        endcase
    end

    always @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_r     <= `FPCRO_ST_IDLE;
            rd_cnt_r    <= 8'h00;
            result_r    <= 8'h00;
            done_r      <= 1'b0;
            erase_r     <= 1'b0;
            erase_blk_r <= 4'h0;
            dest_r      <= 32'h00000000;
            src_r       <= 32'h00000000;
        end else begin
            state_r  <= state_nxt;
            rd_cnt_r <= rd_cnt_nxt;
            result_r <= result_nxt;
            done_r   <= done_nxt;
            erase_r  <= erase_nxt;
            if (state_r == `FPCRO_ST_IDLE && ERASE_START && !PROG_START) begin
                erase_blk_r <= ERASE_BLOCK_NUM[3:0];
            end
            // parameters are latched so the cpu may reuse its registers
            if (state_r == `FPCRO_ST_IDLE && PROG_START) begin
                dest_r <= PROG_DEST_ADDR;
                src_r  <= PROG_SRC_ADDR;
            end
        end
    end

    // source fetch: one byte per cycle, data returns a cycle later
    always @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rd_en_r   <= 1'b0;
            rd_pend_r <= 1'b0;
        end else begin
            rd_en_r   <= (state_r == `FPCRO_ST_PROG) &&
                         (rd_cnt_r != `FPCRO_PROG_BYTES);
            rd_pend_r <= rd_en_r;
        end
    end

    reg [31:0] rd_addr_r;

    always @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rd_addr_r <= 32'h00000000;
        end else if (state_r == `FPCRO_ST_PROG) begin
            rd_addr_r <= src_r + {24'h000000, rd_cnt_r};
        end
    end

    // array write: each returned byte goes to the next destination byte
    always @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            flash_we_r   <= 1'b0;
            flash_addr_r <= 32'h00000000;
            flash_data_r <= 8'h00;
            wr_cnt_r     <= 7'h00;
            last_wr_r    <= 1'b0;
        end else begin
            flash_we_r <= rd_pend_r;
            last_wr_r  <= 1'b0;
            if (state_r == `FPCRO_ST_IDLE) begin
                wr_cnt_r <= 7'h00;
            end else if (rd_pend_r) begin
                flash_addr_r <= dest_r + {25'h0000000, wr_cnt_r};
                flash_data_r <= SRC_RD_DATA;
                wr_cnt_r     <= wr_cnt_r + 7'h01;
                last_wr_r    <= (wr_cnt_r == `FPCRO_PROG_LAST);
            end
        end
    end

    // outputs
    assign BUSY              = (state_r != `FPCRO_ST_IDLE);
    assign DONE              = done_r;
    assign RESULT_FLAGS      = result_r;
    assign SRC_RD_EN         = rd_en_r;
    assign SRC_RD_ADDR       = rd_addr_r;
    // gated here as well, so emulation switched on mid-program still blocks the array
    assign FLASH_WE          = flash_we_r && !emu_on;
    assign FLASH_WADDR       = flash_addr_r;
    assign FLASH_WDATA       = flash_data_r;
    assign FLASH_ERASE       = erase_r && !emu_on;
    assign FLASH_ERASE_BLOCK = erase_blk_r;

endmodule
`default_nettype wire

/* File: hdl/fpcro_map.vh */
// Purpose: constants for the flash parameter check and RAM overlay block
// Assumes: included by bare name from hdl/
// Notes:   definitions only
`ifndef FPCRO_MAP_VH
`define FPCRO_MAP_VH

// programming unit and erase block range
`define FPCRO_PROG_BYTES     8'h80
`define FPCRO_PROG_LAST      7'h7F
`define FPCRO_ALIGN_BITS     7
`define FPCRO_BLOCK_LAST     32'h0000000B

// flash area, base zero, last byte address (default of a parameter)
`define FPCRO_FLASH_LAST     32'h0007FFFF

// result flag positions
`define FPCRO_SF_BIT         0
`define FPCRO_EB_BIT         3
`define FPCRO_WA_BIT         5
`define FPCRO_WD_BIT         6

// overlay control layout and reset value
`define FPCRO_OVL_SEL_BIT    3
`define FPCRO_OVL_AREA_MSB   2
`define FPCRO_OVL_RESET      4'h0
`define FPCRO_OVL_RAM_BASE   24'hFFA000
`define FPCRO_OVL_BLK_SHIFT  12

// sequencer states
`define FPCRO_ST_IDLE        2'h0
`define FPCRO_ST_PROG        2'h1
`define FPCRO_ST_DONE        2'h2

`endif

/* File: hdl/fpcro_overlay.v */
// Purpose: overlay control register and flash-to-RAM address redirection
// Assumes: one clock, asynchronous active-low reset
// Notes:   redirection is combinational so a read lands in the same cycle
`include "fpcro_map.vh"
`timescale 1ns/10ps
`default_nettype none

module fpcro_overlay (
    // clock and reset
    input  wire        clk,
    input  wire        reset_n,
    // register access
    input  wire        ctl_we,
    input  wire [7:0]  ctl_wdata,
    output wire [7:0]  ctl_rdata,
    // cpu read address
    input  wire [23:0] cpu_addr,
    output wire        ovl_hit,
    output wire [23:0] ovl_addr,
    // state
    output wire        emu_on
);

    reg  [3:0] ctl_r;
    wire [3:0] ctl_nxt;

    // upper nibble is never stored, so writes there vanish
    assign ctl_nxt = ctl_we ? ctl_wdata[3:0] : ctl_r;

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctl_r <= `FPCRO_OVL_RESET;
        end else begin
            ctl_r <= ctl_nxt;
        end
    end

    assign ctl_rdata = {4'h0, ctl_r};
    assign emu_on    = ctl_r[`FPCRO_OVL_SEL_BIT];

    // area select counts only while emulation is on
    assign ovl_hit = emu_on &&
                     (cpu_addr[23:15] == 9'h000) &&
                     (cpu_addr[14:12] == ctl_r[`FPCRO_OVL_AREA_MSB:0]);

    // same low 12-bit offset inside the ram window
    assign ovl_addr = ovl_hit ? (`FPCRO_OVL_RAM_BASE | {12'h000, cpu_addr[11:0]})
                              : cpu_addr;

endmodule
`default_nettype wire

/* File: testbench/fpcro_top_chk.sv */
// Purpose: port assertions for fpcro_top
// Assumes: one clock, async active-low reset
// Notes:   program walk checked at first bytes and at the end only
`timescale 1ns/10ps
`default_nettype none
module fpcro_chk #(parameter [31:0] FLASH_LAST = 32'h0007FFFF) (
    // clock and reset
    input wire logic        CORE_CLK,
    input wire logic        RESET_N,
    // commands
    input wire logic [31:0] PROG_DEST_ADDR,
    input wire logic [31:0] PROG_SRC_ADDR,
    input wire logic [31:0] ERASE_BLOCK_NUM,
    input wire logic        PROG_START,
    input wire logic        ERASE_START,
    // status and array side
    input wire logic        BUSY,
    input wire logic        DONE,
    input wire logic [7:0]  RESULT_FLAGS,
    input wire logic        SRC_RD_EN,
    input wire logic [31:0] SRC_RD_ADDR,
    input wire logic        FLASH_WE,
    input wire logic [31:0] FLASH_WADDR,
    input wire logic        FLASH_ERASE,
    input wire logic [3:0]  FLASH_ERASE_BLOCK,
    // overlay
    input wire logic        OVL_CTL_WE,
    input wire logic [7:0]  OVL_CTL_WDATA,
    input wire logic [7:0]  OVL_CTL_RDATA,
    input wire logic [23:0] CPU_ADDR,
    input wire logic        OVL_HIT,
    input wire logic [23:0] OVL_ADDR
);
    wire emu  = OVL_CTL_RDATA[3];
    wire e_tk = ERASE_START && !PROG_START && !BUSY && !emu;
    wire p_tk = PROG_START && !BUSY && !emu;
    wire p_ok = p_tk && PROG_DEST_ADDR[6:0] == 7'h00 && PROG_DEST_ADDR <= FLASH_LAST
                && PROG_SRC_ADDR > FLASH_LAST;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESET_N);
    a_erase_bad: assert property (e_tk && ERASE_BLOCK_NUM > 32'h0000000B |=>
        RESULT_FLAGS == 8'h09 && DONE && !FLASH_ERASE) else $error("bad block not flagged");
    a_erase_good: assert property (e_tk && ERASE_BLOCK_NUM <= 32'h0000000B |=>
        FLASH_ERASE && RESULT_FLAGS == 8'h00 && FLASH_ERASE_BLOCK == $past(ERASE_BLOCK_NUM[3:0]))
        else $error("good erase wrong");
    a_dest_bad: assert property (p_tk && (PROG_DEST_ADDR[6:0] != 7'h00 ||
        PROG_DEST_ADDR > FLASH_LAST) |=> DONE && RESULT_FLAGS[5] && RESULT_FLAGS[0])
        else $error("dest error not flagged");
    a_src_bad: assert property (p_tk && PROG_SRC_ADDR <= FLASH_LAST |=>
        DONE && RESULT_FLAGS[6] && RESULT_FLAGS[0]) else $error("src error not flagged");
    a_prog_walk: assert property (p_ok |=> BUSY ##1 SRC_RD_EN &&
        SRC_RD_ADDR == $past(PROG_SRC_ADDR, 2) ##2 FLASH_WE &&
        FLASH_WADDR == $past(PROG_DEST_ADDR, 4)) else $error("program walk wrong");
    a_prog_end: assert property (p_ok |-> ##[130:140] (DONE && RESULT_FLAGS == 8'h00))
        else $error("program did not end cleanly");
    a_emu_lock: assert property (emu |-> !FLASH_WE && !FLASH_ERASE)
        else $error("array touched under emulation");
    a_ctl_write: assert property (OVL_CTL_WE |=>
        OVL_CTL_RDATA == {4'h0, $past(OVL_CTL_WDATA[3:0])}) else $error("ctl write wrong");
    a_ovl_hit: assert property (OVL_HIT == (emu && CPU_ADDR[23:15] == 9'h000 &&
        CPU_ADDR[14:12] == OVL_CTL_RDATA[2:0])) else $error("overlay hit wrong");
    a_ovl_addr: assert property (OVL_HIT |-> OVL_ADDR == {12'hFFA, CPU_ADDR[11:0]})
        else $error("overlay address wrong");
endmodule
bind fpcro_top fpcro_chk #(.FLASH_LAST(FLASH_LAST)) u_fpcro_chk (.CORE_CLK, .RESET_N,
    .PROG_DEST_ADDR, .PROG_SRC_ADDR, .ERASE_BLOCK_NUM, .PROG_START, .ERASE_START, .BUSY,
    .DONE, .RESULT_FLAGS, .SRC_RD_EN, .SRC_RD_ADDR, .FLASH_WE, .FLASH_WADDR, .FLASH_ERASE,
    .FLASH_ERASE_BLOCK, .OVL_CTL_WE, .OVL_CTL_WDATA, .OVL_CTL_RDATA, .CPU_ADDR, .OVL_HIT,
    .OVL_ADDR);
`default_nettype wire

/* File: testbench/fpcro_top_tb.sv */
// Purpose: self-checking bench for fpcro_top
// Assumes: inputs change on the falling edge
// Notes:   source memory answers one cycle late, line scrambled when idle
`timescale 1ns/10ps
`default_nettype none
module fpcro_top_tb;
    logic        clk, rst_n, p_go, e_go, c_we, en_d;
    logic [31:0] dst, src, blk, a_d, exp_d, exp_s;
    logic [7:0]  c_wd, s_data;
    logic [23:0] cpu_a;
    wire         busy, done, s_en, f_we, f_er, hit;
    wire  [7:0]  flags, c_rd, f_wd;
    wire  [31:0] s_addr, f_wa;
    wire  [3:0]  f_blk;
    wire  [23:0] o_addr;
    int          n_mismatch = 0, n_tests = 0, n_wr = 0;

    fpcro_top #(.FLASH_LAST(32'h0007FFFF)) u_fpcro_top (.CORE_CLK(clk), .RESET_N(rst_n),
        .PROG_DEST_ADDR(dst), .PROG_SRC_ADDR(src), .ERASE_BLOCK_NUM(blk), .PROG_START(p_go),
        .ERASE_START(e_go), .BUSY(busy), .DONE(done), .RESULT_FLAGS(flags), .SRC_RD_EN(s_en),
        .SRC_RD_ADDR(s_addr), .SRC_RD_DATA(s_data), .FLASH_WE(f_we), .FLASH_WADDR(f_wa),
        .FLASH_WDATA(f_wd), .FLASH_ERASE(f_er), .FLASH_ERASE_BLOCK(f_blk), .OVL_CTL_WE(c_we),
        .OVL_CTL_WDATA(c_wd), .OVL_CTL_RDATA(c_rd), .CPU_ADDR(cpu_a), .OVL_HIT(hit),
        .OVL_ADDR(o_addr));

    initial begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(string nm, logic [31:0] ex, logic [31:0] got);
        n_tests++;
        if (got !== ex) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic end_sim;
        if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // stale data is inverted so a late sample cannot pass by luck
    always @(negedge clk) begin
        en_d <= s_en;
        a_d <= s_addr;
        s_data <= en_d ? a_d[7:0] ^ 8'h5A : ~s_data;
    end

    // sampled mid-cycle, away from the edge that launches each write
    always @(negedge clk) begin
        if (f_we) begin
            chk("flash addr", exp_d + n_wr, f_wa);
            chk("flash data", {24'h0, (exp_s[7:0] + n_wr[7:0]) ^ 8'h5A}, {24'h0, f_wd});
            n_wr++;
        end
    end

    task automatic cmd(logic p, logic [31:0] d, s, b, logic [7:0] fl, logic er, int wr);
        int i;
        dst = d; src = s; blk = b; p_go = p; e_go = !p;
        exp_d = d; exp_s = s; n_wr = 0;
        @(negedge clk);
        p_go = 0; e_go = 0;
        chk("busy", wr != 0, busy);
        for (i = 0; i < 140 && done !== 1'b1; i++) @(negedge clk);
        chk("done", 1, done);
        chk("flags", fl, flags);
        chk("erase", er, f_er);
        if (er) chk("block", b, f_blk);
        chk("writes", wr, n_wr);
    endtask

    // a gap after each write keeps software off the block while it switches
    task automatic ctl(logic [7:0] v);
        c_wd = v;
        c_we = 1;
        @(negedge clk);
        c_we = 0;
        @(negedge clk);
    endtask

    initial begin
        {p_go, e_go, c_we, dst, src, blk, c_wd, cpu_a, s_data, en_d, a_d} = '0;
        rst_n = 0;
        repeat (5) @(negedge clk);
        rst_n = 1;
        chk("ctl reset", 0, c_rd);
        ctl(8'hFF); chk("ctl upper", 8'h0F, c_rd);
        for (int k = 0; k < 8; k++) begin
            ctl({5'h01, k[2:0]});
            cpu_a = {9'h000, k[2:0], 12'h123};
            #1 chk("hit", 1, hit);
            chk("ovl addr", 24'hFFA123, o_addr);
            cpu_a = cpu_a ^ 24'h001000;
            #1 chk("miss", 0, hit);
            chk("pass addr", cpu_a, o_addr);
            cpu_a = cpu_a ^ 24'h001000;
            ctl({5'h00, k[2:0]}); chk("off", 0, hit);
        end
        ctl(8'h08);
        cmd(1, 32'h1000, 32'h00FFA000, 0, 8'h01, 0, 0);
        cmd(0, 0, 0, 3, 8'h01, 0, 0);
        ctl(8'h00);
        cmd(1, 32'h1000, 32'h00FFA000, 0, 8'h00, 0, 128);
        cmd(1, 32'h0007FF80, 32'h00080000, 0, 8'h00, 0, 128);
        cmd(1, 32'h1040, 32'h00FFA000, 0, 8'h21, 0, 0);
        cmd(1, 32'h00080000, 32'h00FFA000, 0, 8'h21, 0, 0);
        cmd(1, 32'h2000, 32'h0007FFFF, 0, 8'h41, 0, 0);
        for (int b = 0; b < 12; b++) cmd(0, 0, 0, b, 8'h00, 1, 0);
        cmd(0, 0, 0, 12, 8'h09, 0, 0);
        cmd(0, 0, 0, 32'h8000000B, 8'h09, 0, 0);
        ctl(8'h0B);
        chk("ctl set", 8'h0B, c_rd);
        rst_n = 0;
        @(negedge clk);
        rst_n = 1;
        chk("ctl re-reset", 0, c_rd);
        @(negedge clk);
        end_sim;
    end

    initial begin
        #(25 * 5000);
        n_mismatch++;
        end_sim;
    end
endmodule
`default_nettype wire
